/* File: hw/gor_pkg.sv */
// Constants and types of the rate output and power control register slice
package gor_pkg;

	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [7:0] ADDR_RATE_X_HIGH = 8'h43;
	localparam logic [7:0] ADDR_RATE_X_LOW = 8'h44;
	localparam logic [7:0] ADDR_RATE_Y_HIGH = 8'h45;
	localparam logic [7:0] ADDR_RATE_Y_LOW = 8'h46;
	localparam logic [7:0] ADDR_RATE_Z_HIGH = 8'h47;
	localparam logic [7:0] ADDR_RATE_Z_LOW = 8'h48;
	localparam logic [7:0] ADDR_THERMO_RST = 8'h68;
	localparam logic [7:0] ADDR_IF_BUF = 8'h6a;
	localparam logic [7:0] ADDR_PWR_TB = 8'h6b;

	// ****************************************************************
	// Field positions and reset values
	// ****************************************************************
	localparam int BIT_THERMO_RST = 0;
	localparam int BIT_BUF_EN = 6;
	localparam int BIT_PORT_OFF = 4;
	localparam int BIT_FLUSH = 2;
	localparam int BIT_PATH_CLEAR = 0;
	localparam int BIT_DEV_RST = 7;
	localparam int BIT_SLEEP = 6;
	localparam int BIT_STANDBY = 4;
	localparam int BIT_THERMO_OFF = 3;
	localparam int TB_MSB = 2;
	localparam logic SLEEP_RST = 1'h1;
	localparam logic [2:0] TB_RST = 3'h0;
	localparam logic [2:0] TB_PLL_LO = 3'h1;
	localparam logic [2:0] TB_PLL_HI = 3'h5;
	localparam logic [2:0] TB_STOP = 3'h7;

	// ****************************************************************
	// Serial port, scaling and timing
	// ****************************************************************
	localparam logic [6:0] I2C_BASE_ADDR = 7'h68;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [2:0] SPI_LAST_BIT = 3'h7;
	localparam logic [6:0] PIN_IDLE = 7'h0f;
	localparam logic [7:0] SENS_FS0 = 8'h83;
	localparam logic signed [15:0] RATE_MAX = 16'sh7fff;
	localparam logic signed [15:0] RATE_MIN = -16'sh8000;
	localparam int SYS_MHZ = 50;
	localparam int OSC_MHZ = 20;

	typedef enum logic [3:0] {
		I_IDLE, I_ADDR, I_ACK_A, I_REG, I_ACK_R,
		I_WDATA, I_ACK_W, I_RDATA, I_RACK
	} gor_i2c_st_t;

endpackage

/* File: hw/gor_sync2.sv */
// Two flip-flop synchroniser for pins entering the system clock domain
`timescale 1ns/1ps
module gor_sync2 #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Pins
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			meta <= RST_VAL;
			sync_out <= RST_VAL;
		end else begin
			meta <= async_in;
			sync_out <= meta;
		end
	end
endmodule // gor_sync2

/* File: hw/gor_regs.sv */
// Rate output, path reset, interface and power control register slice
// Contract
// - X rate is signed 16 bits, high byte 0x43, low byte 0x44.
// - Y rate is 16 bits, high byte 0x45, low byte 0x46.
// - Z rate is 16 bits, high byte 0x47, low byte 0x48.
// - Output is sensitivity times rate; range zero gives 131 counts per dps.
// - Writing one to bit 0 of 0x68 resets thermometer path only.
// - Bit 6 of 0x6a opens the buffer to the serial port.
// - Bit 4 of 0x6a turns the two-wire slave off, SPI only.
// - Bit 2 of 0x6a flushes the buffer, clears after one 20 MHz cycle.
// - Bit 0 of 0x6a resets both paths and clears rate outputs.
// - Bit 7 of 0x6b restores all defaults, then clears itself.
// - Bit 6 of 0x6b is sleep; it is one after reset.
// - Bit 4 of 0x6b keeps drive and PLL but stops sense paths.
// - Bit 3 of 0x6b turns the thermometer off.
// - Timebase codes 0 and 6 use oscillator; 1 to 5 PLL when ready.
// - Timebase code 7 stops the clock, holds timing generator in reset.
// - Two-wire slave address is 0x68 or 0x69 from the address pin.
// - Samples go to the buffer only when their source enables are set.
`timescale 1ns/1ps
module gor_regs
	import gor_pkg::*;
#(
	parameter logic [7:0] SENS_FS1 = 8'h42,
	parameter logic [7:0] SENS_FS2 = 8'h21,
	parameter logic [7:0] SENS_FS3 = 8'h10
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Two-wire pins, open drain
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic addr_lsb_pin,
	// Four-wire pins
	input wire logic spi_cs_n,
	input wire logic spi_sclk,
	input wire logic spi_mosi,
	output logic spi_miso,
	output logic spi_miso_oe_n,
	// Sense path
	input wire logic sample_strobe,
	input wire logic signed [15:0] ang_rate_x,
	input wire logic signed [15:0] ang_rate_y,
	input wire logic signed [15:0] ang_rate_z,
	input wire logic [1:0] range_choice,
	input wire logic pll_ready,
	// Sample buffer side
	input wire logic [2:0] buf_src_en,
	output logic [2:0] buf_push,
	output logic signed [15:0] rate_x_sample,
	output logic signed [15:0] rate_y_sample,
	output logic signed [15:0] rate_z_sample,
	output logic buffer_port_open,
	output logic buffer_flush,
	// Power and path control
	output logic thermo_path_rst,
	output logic rate_path_rst,
	output logic sleep_mode,
	output logic gyro_drive_on,
	output logic sense_enable,
	output logic thermometer_off,
	output logic timebase_use_pll,
	output logic timing_gen_rst,
	output logic two_wire_port_off
);

	// ****************************************************************
	// Pin synchronisers and edges
	// ****************************************************************
	logic [6:0] pins_s;
	logic scl_d, sda_d, sclk_d;
	wire scl_s = pins_s[0];
	wire sda_s = pins_s[1];
	wire cs_n_s = pins_s[2];
	wire sclk_s = pins_s[3];
	wire mosi_s = pins_s[4];
	wire addr_lsb_s = pins_s[5];
	wire pll_ready_s = pins_s[6];

	gor_sync2 #(.WIDTH(7), .RST_VAL(PIN_IDLE)) u_sync (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.async_in({pll_ready, addr_lsb_pin, spi_mosi, spi_sclk, spi_cs_n,
			sda_in, scl_in}),
		.sync_out(pins_s)
	);

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			scl_d <= 1'h1;
			sda_d <= 1'h1;
			sclk_d <= 1'h1;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
			sclk_d <= sclk_s;
		end
	end

	wire scl_rise = scl_s & ~scl_d;
	wire scl_fall = ~scl_s & scl_d;
	wire i2c_start = scl_s & scl_d & sda_d & ~sda_s;
	wire i2c_stop = scl_s & scl_d & ~sda_d & sda_s;
	wire sclk_rise = sclk_s & ~sclk_d;
	wire sclk_fall = ~sclk_s & sclk_d;

	// ****************************************************************
	// Control registers and shared write port
	// ****************************************************************
	logic buf_en, port_off, flush, dev_rst, sleep, standby, thermo_off;
	logic [2:0] timebase;
	logic [5:0] osc_acc;
	logic i2c_wr, spi_wr;
	logic [7:0] i2c_sh, i2c_ptr, spi_wa, spi_wd;

	wire wr_en = i2c_wr | spi_wr;
	wire [7:0] wr_addr = spi_wr ? spi_wa : i2c_ptr;
	wire [7:0] wr_data = spi_wr ? spi_wd : i2c_sh;
	wire wr_if_buf = wr_en && wr_addr == ADDR_IF_BUF;
	wire wr_pwr = wr_en && wr_addr == ADDR_PWR_TB;
	wire thermo_hit = wr_en && wr_addr == ADDR_THERMO_RST &&
		wr_data[BIT_THERMO_RST];
	wire path_clear = wr_if_buf && wr_data[BIT_PATH_CLEAR];
	wire [5:0] osc_sum = osc_acc + 6'(OSC_MHZ);
	wire tick20 = osc_sum >= 6'(SYS_MHZ);

	// Oscillator-rate enable from a fractional divider
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			osc_acc <= '0;
		else
			osc_acc <= tick20 ? osc_sum - 6'(SYS_MHZ) : osc_sum;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst || dev_rst) begin
			buf_en <= 1'h0;
			port_off <= 1'h0;
			flush <= 1'h0;
			dev_rst <= 1'h0;
			sleep <= SLEEP_RST;
			standby <= 1'h0;
			thermo_off <= 1'h0;
			timebase <= TB_RST;
		end else begin
			if (flush && tick20)
				flush <= 1'h0;
			if (wr_if_buf) begin
				buf_en <= wr_data[BIT_BUF_EN];
				port_off <= wr_data[BIT_PORT_OFF];
				if (wr_data[BIT_FLUSH])
					flush <= 1'h1;
			end
			if (wr_pwr) begin
				dev_rst <= wr_data[BIT_DEV_RST];
				sleep <= wr_data[BIT_SLEEP];
				standby <= wr_data[BIT_STANDBY];
				thermo_off <= wr_data[BIT_THERMO_OFF];
				timebase <= wr_data[TB_MSB:0];
			end
		end
	end

	wire tb_pll_code = timebase >= TB_PLL_LO && timebase <= TB_PLL_HI;
	wire sense_on = ~sleep & ~standby & (timebase != TB_STOP);

	assign buffer_port_open = buf_en;
	assign buffer_flush = flush;
	assign two_wire_port_off = port_off;
	assign sleep_mode = sleep;
	assign gyro_drive_on = ~sleep;
	assign sense_enable = sense_on;
	assign thermometer_off = thermo_off | sleep;
	assign timebase_use_pll = tb_pll_code & pll_ready_s;
	assign timing_gen_rst = timebase == TB_STOP;

	// ****************************************************************
	// Rate samples and buffer pushes
	// ****************************************************************
	function automatic logic signed [15:0] scale(
		input logic signed [15:0] r);
		logic [7:0] s;
		logic signed [24:0] p;
		case (range_choice)
		2'h0: s = SENS_FS0;
		2'h1: s = SENS_FS1;
		2'h2: s = SENS_FS2;
		default: s = SENS_FS3;
		endcase
		p = r * $signed({1'b0, s});
		if (p > 25'(RATE_MAX))
			scale = RATE_MAX;
		else if (p < 25'(RATE_MIN))
			scale = RATE_MIN;
		else
			scale = p[15:0];
	endfunction

	wire capture = sample_strobe & sense_on;

	always_ff @(posedge sys_clk) begin
		if (sys_rst || dev_rst || path_clear) begin
			rate_x_sample <= '0;
			rate_y_sample <= '0;
			rate_z_sample <= '0;
			buf_push <= '0;
		end else begin
			buf_push <= {3{capture}} & buf_src_en;
			if (capture) begin
				rate_x_sample <= scale(ang_rate_x);
				rate_y_sample <= scale(ang_rate_y);
				rate_z_sample <= scale(ang_rate_z);
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			thermo_path_rst <= 1'h0;
			rate_path_rst <= 1'h0;
		end else begin
			thermo_path_rst <= thermo_hit | path_clear;
			rate_path_rst <= path_clear;
		end
	end

	// Rate outputs have no write decode, so writes there fall away
	function automatic logic [7:0] reg_read(input logic [7:0] a);
		case (a)
		ADDR_RATE_X_HIGH: reg_read = rate_x_sample[15:8];
		ADDR_RATE_X_LOW: reg_read = rate_x_sample[7:0];
		ADDR_RATE_Y_HIGH: reg_read = rate_y_sample[15:8];
		ADDR_RATE_Y_LOW: reg_read = rate_y_sample[7:0];
		ADDR_RATE_Z_HIGH: reg_read = rate_z_sample[15:8];
		ADDR_RATE_Z_LOW: reg_read = rate_z_sample[7:0];
		ADDR_IF_BUF: reg_read = {1'b0, buf_en, 1'b0, port_off, 1'b0,
			flush, 2'b00};
		ADDR_PWR_TB: reg_read = {dev_rst, sleep, 1'b0, standby,
			thermo_off, timebase};
		default: reg_read = 8'h00;
		endcase
	endfunction

	// ****************************************************************
	// Two-wire slave
	// ****************************************************************
	gor_i2c_st_t i2c_st;
	logic [3:0] i2c_cnt;
	logic i2c_rw, i2c_nack;
	wire addr_hit = i2c_sh[7:1] == {I2C_BASE_ADDR[6:1], addr_lsb_s};

	always_ff @(posedge sys_clk) begin
		if (sys_rst || dev_rst || port_off) begin
			i2c_st <= I_IDLE;
			i2c_cnt <= '0;
			i2c_sh <= '0;
			i2c_ptr <= '0;
			i2c_rw <= 1'h0;
			i2c_nack <= 1'h0;
			i2c_wr <= 1'h0;
		end else begin
			i2c_wr <= 1'h0;
			if (i2c_stop) begin
				i2c_st <= I_IDLE;
			end else if (i2c_start) begin
				i2c_st <= I_ADDR;
				i2c_cnt <= '0;
			end else if (scl_rise) begin
				if (i2c_st == I_ADDR || i2c_st == I_REG ||
					i2c_st == I_WDATA) begin
					i2c_sh <= {i2c_sh[6:0], sda_s};
					i2c_cnt <= i2c_cnt + 4'h1;
				end
				if (i2c_st == I_RACK)
					i2c_nack <= sda_s;
			end else if (scl_fall) begin
				case (i2c_st)
				I_ADDR: if (i2c_cnt == BYTE_BITS) begin
					i2c_rw <= i2c_sh[0];
					i2c_st <= addr_hit ? I_ACK_A : I_IDLE;
				end
				I_ACK_A: begin
					i2c_cnt <= '0;
					if (i2c_rw) begin
						i2c_sh <= reg_read(i2c_ptr);
						i2c_st <= I_RDATA;
					end else
						i2c_st <= I_REG;
				end
				I_REG: if (i2c_cnt == BYTE_BITS) begin
					i2c_ptr <= i2c_sh;
					i2c_st <= I_ACK_R;
				end
				I_ACK_R: begin
					i2c_cnt <= '0;
					i2c_st <= I_WDATA;
				end
				I_WDATA: if (i2c_cnt == BYTE_BITS) begin
					i2c_wr <= 1'h1;
					i2c_st <= I_ACK_W;
				end
				I_ACK_W: begin
					i2c_cnt <= '0;
					i2c_ptr <= i2c_ptr + 8'h01;
					i2c_st <= I_WDATA;
				end
				I_RDATA: if (i2c_cnt == BYTE_BITS - 4'h1) begin
					i2c_ptr <= i2c_ptr + 8'h01;
					i2c_st <= I_RACK;
				end else begin
					i2c_sh <= {i2c_sh[6:0], 1'b0};
					i2c_cnt <= i2c_cnt + 4'h1;
				end
				I_RACK: if (i2c_nack)
					i2c_st <= I_IDLE;
				else begin
					i2c_sh <= reg_read(i2c_ptr);
					i2c_cnt <= '0;
					i2c_st <= I_RDATA;
				end
				default: i2c_st <= I_IDLE;
				endcase
			end
		end
	end

	wire i2c_ack = i2c_st == I_ACK_A || i2c_st == I_ACK_R ||
		i2c_st == I_ACK_W;
	assign sda_out = 1'h0;
	assign sda_oe_n = ~(i2c_ack || (i2c_st == I_RDATA && !i2c_sh[7]));

	// ****************************************************************
	// Four-wire slave: first byte is read flag and address
	// ****************************************************************
	logic [2:0] spi_cnt;
	logic [7:0] spi_sh, spi_tx, spi_ptr;
	logic spi_first, spi_rd;
	wire [7:0] spi_byte = {spi_sh[6:0], mosi_s};
	wire [7:0] spi_addr = {1'b0, spi_byte[6:0]};

	always_ff @(posedge sys_clk) begin
		if (sys_rst || dev_rst || cs_n_s) begin
			spi_cnt <= '0;
			spi_sh <= '0;
			spi_tx <= '0;
			spi_ptr <= '0;
			spi_first <= 1'h1;
			spi_rd <= 1'h0;
			spi_wr <= 1'h0;
			spi_wa <= '0;
			spi_wd <= '0;
		end else begin
			spi_wr <= 1'h0;
			if (sclk_rise) begin
				spi_sh <= spi_byte;
				spi_cnt <= spi_cnt + 3'h1;
				if (spi_cnt == SPI_LAST_BIT) begin
					spi_first <= 1'h0;
					if (spi_first) begin
						spi_rd <= spi_byte[7];
						spi_ptr <= spi_byte[7] ? spi_addr + 8'h01 : spi_addr;
						spi_tx <= reg_read(spi_addr);
					end else if (spi_rd) begin
						spi_tx <= reg_read(spi_ptr);
						spi_ptr <= spi_ptr + 8'h01;
					end else begin
						spi_wr <= 1'h1;
						spi_wa <= spi_ptr;
						spi_wd <= spi_byte;
						spi_ptr <= spi_ptr + 8'h01;
					end
				end
			end else if (sclk_fall && spi_cnt != 3'h0) begin
				spi_tx <= {spi_tx[6:0], 1'b0};
			end
		end
	end

	assign spi_miso = spi_tx[7];
	assign spi_miso_oe_n = cs_n_s;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	sequence s_flush_set;
		wr_if_buf && wr_data[BIT_FLUSH];
	endsequence
	sequence s_flush_gone;
		flush ##[1:3] !flush;
	endsequence

	chk_flush_pulse: assert property (
		s_flush_set |=> s_flush_gone)
		else $error("flush bit did not self-clear in time");
	chk_ro_writes: assert property (
		wr_en && wr_addr >= ADDR_RATE_X_HIGH &&
		wr_addr <= ADDR_RATE_Z_LOW && !capture && !dev_rst
		|=> $stable(rate_x_sample) && $stable(rate_z_sample))
		else $error("rate output changed on a host write");
	chk_path_clear: assert property (
		path_clear |=> rate_x_sample == 16'h0000 &&
		rate_y_sample == 16'h0000 && rate_z_sample == 16'h0000 &&
		rate_path_rst && thermo_path_rst)
		else $error("path clear left outputs set");
	chk_thermo_only: assert property (
		thermo_hit && !path_clear && !capture && !dev_rst
		|=> thermo_path_rst && !rate_path_rst && $stable(rate_y_sample))
		else $error("thermometer reset touched the rate path");
	chk_devrst_defaults: assert property (
		wr_pwr && wr_data[BIT_DEV_RST] |=> dev_rst ##1 (!dev_rst &&
		sleep && timebase == TB_RST && !buf_en))
		else $error("device reset did not restore defaults");
	chk_sleep_gate: assert property (
		sleep |-> !sense_on && thermometer_off && !gyro_drive_on)
		else $error("sleep did not stop the chip");
	chk_standby_gate: assert property (
		standby && !sleep |-> gyro_drive_on && !sense_enable)
		else $error("standby state wrong");
	chk_tb_osc: assert property (
		!tb_pll_code |-> !timebase_use_pll)
		else $error("oscillator code picked the PLL");
	chk_tb_stop: assert property (
		timebase == TB_STOP |-> timing_gen_rst && !sense_enable)
		else $error("stop code did not hold timing generator");
	chk_scale_fs0: assert property (
		capture && range_choice == 2'h0 && ang_rate_x == 16'sh0001 &&
		!path_clear |=> rate_x_sample == 16'(SENS_FS0))
		else $error("range zero sensitivity wrong");
	chk_buf_gate: assert property (
		buf_push[0] |-> $past(buf_src_en[0]) && $past(capture))
		else $error("buffer push without source enable");
	chk_port_off: assert property (
		port_off |=> i2c_st == I_IDLE && sda_oe_n)
		else $error("two-wire slave active while turned off");
	chk_addr_miss: assert property (
		i2c_st == I_ADDR && i2c_cnt == BYTE_BITS && scl_fall &&
		!addr_hit && !i2c_start && !i2c_stop |=> i2c_st == I_IDLE)
		else $error("slave acked a foreign address");

endmodule // gor_regs

/* File: test/gor_host_model.sv */
// Host processor model driving the four-wire and two-wire register ports
`timescale 1ns/1ps
module gor_host_model (
	// Clock
	input wire logic sys_clk,
	// Four-wire pins
	output logic spi_cs_n,
	output logic spi_sclk,
	output logic spi_mosi,
	input wire logic spi_miso,
	// Two-wire pins, data released high by the pull-up
	output logic scl_in,
	output logic sda_drv,
	input wire logic sda_in
);
	// ********************
	// Serial transfers
	// ********************
	// Phases well above the three-cycle minimum of the pin synchronisers
	localparam int HALF = 10;

	initial begin
		spi_cs_n = 1'b1;
		spi_sclk = 1'b0;
		spi_mosi = 1'b0;
		scl_in = 1'b1;
		sda_drv = 1'b1;
	end

	task automatic half();
		repeat (HALF) @(negedge sys_clk);
	endtask

	// Mode 0, read data sampled as the clock rises
	task automatic xfer(input logic [23:0] tx, input int n,
		output logic [23:0] rx);
		rx = '0;
		spi_cs_n = 1'b0;
		half();
		for (int i = 0; i < n; i++) begin
			spi_mosi = tx[23-i];
			half();
			rx[23-i] = spi_miso;
			spi_sclk = 1'b1;
			half();
			spi_sclk = 1'b0;
		end
		half();
		spi_cs_n = 1'b1;
		// Released data line must not keep its last level
		spi_mosi = ~spi_mosi;
		half();
	endtask

	task automatic spi_wr(input logic [7:0] a, input logic [7:0] d);
		logic [23:0] rx;
		xfer({1'b0, a[6:0], d, 8'h00}, 16, rx);
	endtask

	task automatic spi_rd16(input logic [7:0] a, output logic [15:0] d);
		logic [23:0] rx;
		xfer({1'b1, a[6:0], 16'h0000}, 24, rx);
		d = rx[15:0];
	endtask

	// Address phase only, then STOP; reports the device acknowledge
	task automatic i2c_probe(input logic [6:0] a, output logic ack);
		logic [8:0] b;
		b = {a, 2'b01};
		ack = 1'b0;
		sda_drv = 1'b0;
		half();
		scl_in = 1'b0;
		half();
		for (int i = 8; i >= 0; i--) begin
			sda_drv = b[i];
			half();
			scl_in = 1'b1;
			half();
			ack = ~sda_in;
			scl_in = 1'b0;
			half();
		end
		sda_drv = 1'b0;
		half();
		scl_in = 1'b1;
		half();
		sda_drv = 1'b1;
		half();
	endtask
endmodule // gor_host_model

/* File: test/gor_regs_tb.sv */
// Self-checking bench of the rate output and power control registers
`timescale 1ns/1ps
module gor_regs_tb
	import gor_pkg::*;
;
	// ********************
	// Signals and instances
	// ********************
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic addr_lsb_pin = 1'b0;
	logic sample_strobe = 1'b0;
	logic pll_ready = 1'b0;
	logic [2:0] buf_src_en = 3'h0;
	logic signed [15:0] ang_rate_x = '0;
	logic signed [15:0] ang_rate_y = '0;
	logic signed [15:0] ang_rate_z = '0;
	logic scl_in, sda_drv, sda_in, sda_out, sda_oe_n;
	logic spi_cs_n, spi_sclk, spi_mosi, spi_miso, spi_miso_oe_n;
	logic [2:0] buf_push, pushes;
	logic signed [15:0] rate_x_sample, rate_y_sample, rate_z_sample;
	logic buffer_port_open, buffer_flush, thermo_path_rst, rate_path_rst;
	logic sleep_mode, gyro_drive_on, sense_enable, thermometer_off;
	logic timebase_use_pll, timing_gen_rst, two_wire_port_off;
	logic [15:0] rd;
	logic ack;
	int failures = 0;
	int checks = 0;
	int n_th = 0;
	int n_rp = 0;
	int n_fl = 0;

	assign sda_in = sda_drv & (sda_oe_n | sda_out);
	always #10 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		n_th <= n_th + int'(thermo_path_rst);
		n_rp <= n_rp + int'(rate_path_rst);
		n_fl <= n_fl + int'(buffer_flush);
	end

	gor_regs gor_regs_i (.sys_clk, .sys_rst, .scl_in, .sda_in, .sda_out,
		.sda_oe_n, .addr_lsb_pin, .spi_cs_n, .spi_sclk, .spi_mosi,
		.spi_miso, .spi_miso_oe_n, .sample_strobe, .ang_rate_x,
		.ang_rate_y, .ang_rate_z, .range_choice(2'h0), .pll_ready,
		.buf_src_en, .buf_push, .rate_x_sample, .rate_y_sample,
		.rate_z_sample, .buffer_port_open, .buffer_flush,
		.thermo_path_rst, .rate_path_rst, .sleep_mode, .gyro_drive_on,
		.sense_enable, .thermometer_off, .timebase_use_pll,
		.timing_gen_rst, .two_wire_port_off);

	gor_host_model gor_host_model_i (.sys_clk, .spi_cs_n, .spi_sclk,
		.spi_mosi, .spi_miso, .scl_in, .sda_drv, .sda_in);

	// ********************
	// Shared tasks
	// ********************
	task automatic chk(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		gor_host_model_i.spi_wr(a, d);
	endtask

	task automatic rdw(input logic [7:0] a, input logic [15:0] e);
		gor_host_model_i.spi_rd16(a, rd);
		chk($sformatf("reg %h pair", a), rd, e);
	endtask

	task automatic rdb(input logic [7:0] a, input logic [7:0] e);
		gor_host_model_i.spi_rd16(a, rd);
		chk($sformatf("reg %h", a), rd[15:8], e);
	endtask

	task automatic probe(input logic [6:0] a, input logic e);
		gor_host_model_i.i2c_probe(a, ack);
		chk($sformatf("ack %h", a), ack, e);
	endtask

	// One strobe, pushes collected over the following cycles
	task automatic strobe(input logic signed [15:0] x, y, z);
		@(negedge sys_clk);
		ang_rate_x = x;
		ang_rate_y = y;
		ang_rate_z = z;
		sample_strobe = 1'b1;
		@(negedge sys_clk);
		sample_strobe = 1'b0;
		pushes = 3'h0;
		repeat (4) begin
			pushes = pushes | buf_push;
			@(negedge sys_clk);
		end
	endtask

	// ********************
	// Scenarios
	// ********************
	task automatic t_reset();
		chk("sleep", sleep_mode, 1'b1);
		chk("drive", gyro_drive_on, 1'b0);
		chk("use_pll", timebase_use_pll, 1'b0);
		chk("miso_oe_n", spi_miso_oe_n, 1'b1);
		rdb(ADDR_PWR_TB, 8'h40);
	endtask

	task automatic t_wake();
		pll_ready = 1'b1;
		buf_src_en = 3'h5;
		wr(ADDR_PWR_TB, 8'h01);
		chk("use_pll", timebase_use_pll, 1'b1);
		chk("sense", sense_enable, 1'b1);
		chk("th_off", thermometer_off, 1'b0);
		strobe(16'sd1, -16'sd2, 16'sd250);
		chk("push", pushes, 3'h5);
		chk("x", rate_x_sample, 16'd131);
		chk("y", rate_y_sample, -16'sd262);
		chk("z", rate_z_sample, 16'd32750);
		rdw(ADDR_RATE_X_HIGH, 16'd131);
		rdw(ADDR_RATE_Y_HIGH, -16'sd262);
		rdw(ADDR_RATE_Z_HIGH, 16'd32750);
		wr(ADDR_RATE_X_HIGH, 8'h55);
		wr(ADDR_RATE_X_LOW, 8'h55);
		rdw(ADDR_RATE_X_HIGH, 16'd131);
	endtask

	task automatic t_paths();
		n_th = 0;
		n_rp = 0;
		wr(ADDR_THERMO_RST, 8'h01);
		chk("th_pulse", n_th, 16'd1);
		chk("rp_none", n_rp, 16'd0);
		rdw(ADDR_RATE_X_HIGH, 16'd131);
		n_th = 0;
		wr(ADDR_IF_BUF, 8'h01);
		chk("rp_pulse", n_rp, 16'd1);
		chk("th_pulse", n_th, 16'd1);
		chk("x", rate_x_sample, 16'd0);
		chk("z", rate_z_sample, 16'd0);
		rdb(ADDR_IF_BUF, 8'h00);
	endtask

	task automatic t_iface();
		n_fl = 0;
		wr(ADDR_IF_BUF, 8'h54);
		chk("open", buffer_port_open, 1'b1);
		chk("tw_off", two_wire_port_off, 1'b1);
		chk("flush_len", n_fl > 0 && n_fl < 4, 1'b1);
		rdb(ADDR_IF_BUF, 8'h50);
		probe(7'h68, 1'b0);
		wr(ADDR_IF_BUF, 8'h00);
		chk("open", buffer_port_open, 1'b0);
		probe(7'h68, 1'b1);
		addr_lsb_pin = 1'b1;
		probe(7'h68, 1'b0);
		probe(7'h69, 1'b1);
	endtask

	task automatic t_power();
		wr(ADDR_PWR_TB, 8'h11);
		chk("sense", sense_enable, 1'b0);
		chk("drive", gyro_drive_on, 1'b1);
		strobe(16'sd5, 16'sd5, 16'sd5);
		chk("push", pushes, 3'h0);
		chk("x", rate_x_sample, 16'd0);
		wr(ADDR_PWR_TB, 8'h09);
		chk("th_off", thermometer_off, 1'b1);
		for (int c = 0; c < 8; c++) begin
			wr(ADDR_PWR_TB, {5'h00, c[2:0]});
			chk("use_pll", timebase_use_pll, c > 0 && c < 6);
			chk("tg_rst", timing_gen_rst, c == 7);
			chk("sense", sense_enable, c != 7);
		end
		pll_ready = 1'b0;
		wr(ADDR_PWR_TB, 8'h03);
		chk("use_pll", timebase_use_pll, 1'b0);
	endtask

	task automatic t_devrst();
		pll_ready = 1'b1;
		wr(ADDR_PWR_TB, 8'h01);
		wr(ADDR_IF_BUF, 8'h40);
		strobe(16'sd1, 16'sd1, 16'sd1);
		wr(ADDR_PWR_TB, 8'h80);
		chk("sleep", sleep_mode, 1'b1);
		chk("x", rate_x_sample, 16'd0);
		chk("open", buffer_port_open, 1'b0);
		rdb(ADDR_PWR_TB, 8'h40);
	endtask

	task automatic print_verdict();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
		sys_rst = 1'b0;
		repeat (4) @(negedge sys_clk);
		t_reset();
		t_wake();
		t_paths();
		t_iface();
		t_power();
		t_devrst();
		print_verdict();
	end

	initial begin
		repeat (80000) @(posedge sys_clk);
		failures++;
		print_verdict();
	end
endmodule // gor_regs_tb
